//--- hw/rivp_core.sv
// Reset and interrupt vector placement: picks the fetch address after
// reset and for each dispatched interrupt, with boot relocation.
// Assumes the core acknowledges a pending interrupt with a one-cycle
// pulse and that request and enable inputs are synchronous to clk_i.
`timescale 1ns/100ps
module rivp_core
  import rivp_pkg::*;
#(
  parameter bit LARGE_PART = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reset_to_boot_fuse_i,
  input wire logic [RIVP_ADDR_W-1:0] boot_start_i,
  input wire logic ctrl_wr_i,
  input wire logic [1:0] ctrl_wdata_i,
  output logic [1:0] core_control_o,
  input wire logic global_irq_en_i,
  input wire logic [RIVP_NUM_IRQ-1:0] irq_req_i,
  input wire logic [RIVP_NUM_IRQ-1:0] irq_en_i,
  output logic irq_pending_o,
  input wire logic irq_ack_i,
  output logic fetch_valid_o,
  output rivp_fetch_t fetch_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_RESET = 4'b0001,
    ST_BOOT_FETCH = 4'b0010,
    ST_IDLE = 4'b0100,
    ST_DISPATCH = 4'b1000
  } rivp_state_t;

  rivp_state_t state_reg;
  rivp_state_t state_next;
  logic fuse_reg;
  logic vector_boot_select_reg;
  logic vector_change_enable_reg;
  logic [2:0] window_reg;
  rivp_fetch_t fetch_reg;
  logic [RIVP_NUM_IRQ-1:0] masked_req;
  logic winner_found;
  logic [RIVP_VEC_W-1:0] winner_idx;
  logic [RIVP_VEC_W-1:0] winner_vec;
  logic window_open;
  logic take_irq;
  logic [RIVP_ADDR_W-1:0] reset_addr;
  logic [RIVP_ADDR_W-1:0] base_addr;
  logic [RIVP_ADDR_W-1:0] vec_addr;

  // ****************************************************************
  // Fuse capture
  // ****************************************************************
  // Caught while reset is held so a fuse change needs a fresh reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fuse_reg <= reset_to_boot_fuse_i;
    end
  end

  always_comb begin
    if (fuse_reg == RIVP_FUSE_PROGRAMMED) begin
      reset_addr = boot_start_i;
    end else begin
      reset_addr = RIVP_RESET_ADDR;
    end
  end

  // ****************************************************************
  // Protected vector select
  // ****************************************************************
  assign window_open = (window_reg != 3'h0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      window_reg <= 3'h0;
    end else if (ctrl_wr_i && ctrl_wdata_i[RIVP_CE_BIT]) begin
      window_reg <= RIVP_CHANGE_WINDOW;
    end else if (ctrl_wr_i) begin
      window_reg <= 3'h0; // A completing write closes it
    end else if (window_open) begin
      window_reg <= window_reg - 3'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vector_change_enable_reg <= RIVP_CTRL_RESET[RIVP_CE_BIT];
    end else if (ctrl_wr_i) begin
      vector_change_enable_reg <= ctrl_wdata_i[RIVP_CE_BIT];
    end else if (window_reg == 3'h1) begin
      vector_change_enable_reg <= 1'b0;
    end
  end

  // select only moves inside the window
  // Stray writes outside the window are dropped to guard the table
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vector_boot_select_reg <= RIVP_CTRL_RESET[RIVP_SEL_BIT];
    end else if (ctrl_wr_i && window_open &&
                 !ctrl_wdata_i[RIVP_CE_BIT]) begin
      vector_boot_select_reg <= ctrl_wdata_i[RIVP_SEL_BIT];
    end
  end

  // Readback of the control bits
  always_comb begin
    core_control_o = 2'h0;
    core_control_o[RIVP_SEL_BIT] = vector_boot_select_reg;
    core_control_o[RIVP_CE_BIT] = vector_change_enable_reg;
  end

  // ****************************************************************
  // Request arbitration
  // ****************************************************************
  // enabled sources only
  assign masked_req = irq_req_i & irq_en_i;

  rivp_prio_enc #(
    .N(RIVP_NUM_IRQ),
    .W(RIVP_VEC_W)
  ) u_prio (
    .req_i(masked_req),
    .found_o(winner_found),
    .idx_o(winner_idx)
  );

  // Source 0 is vector 2
  assign winner_vec = winner_idx + 5'h2;

  // Interrupts stay off while a select change is under way
  // so a half-moved table is never fetched from
  assign irq_pending_o = winner_found && global_irq_en_i &&
                         !window_open && (state_reg == ST_IDLE);
  assign take_irq = irq_pending_o && irq_ack_i;

  // ****************************************************************
  // Vector address
  // ****************************************************************
  // table entries two words apart on the large part, one word apart when LARGE_PART is clear
  always_comb begin
    if (LARGE_PART) begin
      base_addr = RIVP_VEC_TABLE[winner_vec - 5'h1];
    end else begin
      base_addr = RIVP_VEC_TABLE[winner_vec - 5'h1] >> 1;
    end
  end

  // low table unless select is set
  always_comb begin
    if (vector_boot_select_reg) begin
      vec_addr = base_addr + boot_start_i;
    end else begin
      vec_addr = base_addr;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Two quiet cycles after reset let the core see the reset fetch
  // before any interrupt is offered; a dispatch also takes a cycle,
  // which limits acknowledges to one every second cycle
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RESET: state_next = ST_BOOT_FETCH;
      ST_BOOT_FETCH: state_next = ST_IDLE;
      ST_IDLE: begin
        if (take_irq) begin
          state_next = ST_DISPATCH;
        end
      end
      ST_DISPATCH: state_next = ST_IDLE;
      default: state_next = ST_RESET;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Fetch word is registered so the core sees a steady address
  // for as long as the valid pulse stands
  // all reset causes share vector 1
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fetch_reg <= '0;
    end else if (state_reg == ST_RESET) begin
      fetch_reg.is_reset <= 1'b1;
      fetch_reg.vec_num <= 5'h1;
      fetch_reg.addr <= reset_addr;
    end else if (take_irq) begin
      fetch_reg.is_reset <= 1'b0;
      fetch_reg.vec_num <= winner_vec;
      fetch_reg.addr <= vec_addr;
    end
  end

  assign fetch_o = fetch_reg;
  assign fetch_valid_o = (state_reg == ST_BOOT_FETCH) ||
                         (state_reg == ST_DISPATCH);

  // ****************************************************************
  // Checks
  // ****************************************************************
  // first fetch after reset
  AST_FIRST_FETCH: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |=> fetch_valid_o && fetch_o.is_reset &&
                     fetch_o.vec_num == 5'h1)
    else $error("reset fetch missing after release");

  AST_RESET_ADDR: assert property (@(posedge clk_i) disable iff (rst_i)
    fetch_valid_o && fetch_o.is_reset |->
      fetch_o.addr == (fuse_reg ? RIVP_RESET_ADDR : boot_start_i))
    else $error("reset fetch address wrong for fuse");

  // two-word spacing in the low table
  AST_LOW_TABLE: assert property (@(posedge clk_i) disable iff (rst_i)
    take_irq && !vector_boot_select_reg && LARGE_PART |=>
      fetch_o.addr == {7'h0, $past(winner_vec) - 5'h1, 1'b0})
    else $error("low table vector address wrong");

  // relocated table, expected from the source index alone
  AST_BOOT_TABLE: assert property (@(posedge clk_i) disable iff (rst_i)
    take_irq && vector_boot_select_reg |=>
      fetch_o.addr == $past(boot_start_i) + (LARGE_PART ?
        {7'h0, $past(winner_idx) + 5'h1, 1'b0} :
        {8'h0, $past(winner_idx) + 5'h1}))
    else $error("relocated vector address wrong");

  AST_LOW_SMALL: assert property (@(posedge clk_i) disable iff (rst_i)
    take_irq && !vector_boot_select_reg && !LARGE_PART |=>
      fetch_o.addr == {8'h0, $past(winner_idx) + 5'h1})
    else $error("single-word vector address wrong");

  AST_ENABLED: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_pending_o |-> irq_en_i[winner_idx] && irq_req_i[winner_idx])
    else $error("disabled source offered for dispatch");

  AST_PRIORITY: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_pending_o |->
      (masked_req & ((25'h1 << winner_idx) - 25'h1)) == 25'h0)
    else $error("lower vector number was skipped");

  // window length
  // Looked at on the edge after the fourth idle cycle; on that fourth
  // edge the count still reads one and a write is still welcome
  AST_WINDOW: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_wr_i && ctrl_wdata_i[RIVP_CE_BIT] ##1 !ctrl_wr_i [*4] |=>
      !window_open && !vector_change_enable_reg)
    else $error("change window not closed after four cycles");

  AST_SEL_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(vector_boot_select_reg) |->
      $past(window_open) && $past(ctrl_wr_i))
    else $error("vector select changed without unlock");

  AST_DISPATCH: assert property (@(posedge clk_i) disable iff (rst_i)
    take_irq |=> fetch_valid_o && !fetch_o.is_reset ##1 !fetch_valid_o)
    else $error("dispatch fetch pulse wrong");

  AST_SEL_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_wr_i && window_open && !ctrl_wdata_i[RIVP_CE_BIT] |=>
      vector_boot_select_reg == $past(ctrl_wdata_i[RIVP_SEL_BIT]))
    else $error("unlocked select write did not land");

  AST_FETCH_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    fetch_valid_o |=> !fetch_valid_o)
    else $error("fetch request held too long");

  // fuse copy only moves while reset is held
  AST_FUSE_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> $stable(fuse_reg))
    else $error("fuse copy changed outside reset");

  // nothing offered before the reset fetch is out
  AST_RESET_QUIET: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> !irq_pending_o ##1 !irq_pending_o)
    else $error("interrupt offered too soon after reset");

  // table frozen for the core while a change is open
  AST_WIN_MASK: assert property (@(posedge clk_i) disable iff (rst_i)
    window_open |-> !irq_pending_o)
    else $error("interrupt offered inside change window");

  AST_GIE_MASK: assert property (@(posedge clk_i) disable iff (rst_i)
    !global_irq_en_i |-> !irq_pending_o)
    else $error("interrupt offered while globally disabled");

  AST_DISP_GAP: assert property (@(posedge clk_i) disable iff (rst_i)
    take_irq |=> !irq_pending_o)
    else $error("interrupt offered during dispatch");

endmodule

//--- hw/rivp_pkg.sv
// Shared constants and carrier types for the reset and interrupt vector
// placement block.
// Assumes a word-addressed program memory of at most 8K words.
package rivp_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int RIVP_ADDR_W = 13;
  localparam int RIVP_NUM_VEC = 26;
  localparam int RIVP_NUM_IRQ = 25;
  localparam int RIVP_VEC_W = 5;

  // ****************************************************************
  // Vector table of the two-word part, entry n-1 is vector n
  // ****************************************************************
  localparam logic [12:0] RIVP_VEC_TABLE [RIVP_NUM_VEC] = '{
    13'h0000, 13'h0002, 13'h0004, 13'h0006, 13'h0008, 13'h000a,
    13'h000c, 13'h000e, 13'h0010, 13'h0012, 13'h0014, 13'h0016,
    13'h0018, 13'h001a, 13'h001c, 13'h001e, 13'h0020, 13'h0022,
    13'h0024, 13'h0026, 13'h0028, 13'h002a, 13'h002c, 13'h002e,
    13'h0030, 13'h0032
  };

  // Reset lands here when the fuse leaves the boot section out
  localparam logic [12:0] RIVP_RESET_ADDR = 13'h0000;
  // Fuse value that means programmed
  localparam logic RIVP_FUSE_PROGRAMMED = 1'b0;
  localparam logic RIVP_FUSE_RESET = 1'b1;

  // ****************************************************************
  // Control register layout and timing
  // ****************************************************************
  localparam int RIVP_CE_BIT = 0;
  localparam int RIVP_SEL_BIT = 1;
  localparam logic [1:0] RIVP_CTRL_RESET = 2'h0;
  localparam logic [2:0] RIVP_CHANGE_WINDOW = 3'h4;

  // Fetch request handed to the core
  typedef struct packed {
    logic is_reset;
    logic [4:0] vec_num;
    logic [12:0] addr;
  } rivp_fetch_t;

endpackage

//--- hw/rivp_prio_enc.sv
// Lowest-index-first priority encoder for pending interrupt requests.
// Assumes requests are already gated by their enables.
`timescale 1ns/100ps
module rivp_prio_enc #(
  parameter int N = 25,
  parameter int W = 5
) (
  input wire logic [N-1:0] req_i,
  output logic found_o,
  output logic [W-1:0] idx_o
);

  // ****************************************************************
  // Scan from the top so the lowest index is written last and wins
  // ****************************************************************
  always_comb begin
    found_o = 1'b0;
    idx_o = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        found_o = 1'b1;
        idx_o = W'(i);
      end
    end
  end

endmodule

//--- tb/rivp_core_bench.sv
// Self-checking bench: a two-word part and a single-word part side by side,
// each with its own core model, driven by shared control and requests.
// Assumes the package constants and the hand-over timing of the block.
`timescale 1ns/100ps
module rivp_core_bench
  import rivp_pkg::*;
;
  logic clk, rst, fuse, ctrl_wr, gie;
  logic [12:0] boot_l, boot_s;
  logic [1:0] ctrl_wdata, ctl_l, ctl_s;
  logic [24:0] req, en;
  logic pend_l, pend_s, ack_l, ack_s, fv_l, fv_s;
  rivp_fetch_t f_l, f_s, lf_l, lf_s;
  int cnt_l, cnt_s, errors, compares, c;

  // ****************************************************************
  // Design and core models
  // ****************************************************************
  rivp_core #(.LARGE_PART(1'b1)) DUT (.clk_i(clk), .rst_i(rst),
    .reset_to_boot_fuse_i(fuse), .boot_start_i(boot_l), .ctrl_wr_i(ctrl_wr),
    .ctrl_wdata_i(ctrl_wdata), .core_control_o(ctl_l), .global_irq_en_i(gie),
    .irq_req_i(req), .irq_en_i(en), .irq_pending_o(pend_l),
    .irq_ack_i(ack_l), .fetch_valid_o(fv_l), .fetch_o(f_l));
  rivp_core #(.LARGE_PART(1'b0)) DUT_SMALL (.clk_i(clk), .rst_i(rst),
    .reset_to_boot_fuse_i(fuse), .boot_start_i(boot_s), .ctrl_wr_i(ctrl_wr),
    .ctrl_wdata_i(ctrl_wdata), .core_control_o(ctl_s), .global_irq_en_i(gie),
    .irq_req_i(req), .irq_en_i(en), .irq_pending_o(pend_s),
    .irq_ack_i(ack_s), .fetch_valid_o(fv_s), .fetch_o(f_s));
  // Fast core on one part, slow core on the other
  rivp_core_model #(.DELAY(0)) core_l (.clk_i(clk), .irq_pending_i(pend_l),
    .fetch_valid_i(fv_l), .fetch_i(f_l), .irq_ack_o(ack_l),
    .last_fetch_o(lf_l), .fetch_cnt_o(cnt_l));
  rivp_core_model #(.DELAY(3)) core_s (.clk_i(clk), .irq_pending_i(pend_s),
    .fetch_valid_i(fv_s), .fetch_i(f_s), .irq_ack_o(ack_s),
    .last_fetch_o(lf_s), .fetch_cnt_o(cnt_s));

  always #12.5 clk = ~clk;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic rivp_fetch_t mk(input logic r, input int n,
                                     input logic [12:0] a);
    rivp_fetch_t f;
    f.is_reset = r;
    f.vec_num = 5'(n);
    f.addr = a;
    return f;
  endfunction

  task automatic check_val(input logic [18:0] got, input logic [18:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task print_verdict;
    if (errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Fuse is held through reset; reset fetch lands two cycles after release
  task automatic do_reset(input logic f);
    @(negedge clk);
    rst = 1'b1;
    fuse = f;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  task automatic ctrl_write(input logic [1:0] d);
    @(negedge clk);
    ctrl_wr = 1'b1;
    ctrl_wdata = d;
    @(negedge clk);
    ctrl_wr = 1'b0;
  endtask

  // Unlock then select, second write two cycles after the first
  task automatic set_select;
    ctrl_write(2'h1);
    ctrl_write(2'h2);
    @(negedge clk);
    check_val(ctl_l, 2'h2);
    check_val(ctl_s, 2'h2);
  endtask

  // Holds the request until both cores fetched, then lets in-flight
  // fetches of the same vector settle before comparing
  task automatic take(input logic [24:0] rq, input logic [24:0] ena,
                      input int n, input logic sel);
    int c_l, c_s, k;
    logic [12:0] a_l, a_s;
    c_l = cnt_l;
    c_s = cnt_s;
    @(negedge clk);
    req = rq;
    en = ena;
    gie = 1'b1;
    k = 0;
    while ((cnt_l == c_l || cnt_s == c_s) && k < 40) begin
      @(negedge clk);
      k++;
    end
    req = '0;
    gie = 1'b0;
    repeat (4) @(negedge clk);
    // Two-word part spaces entries two apart, single-word part one apart
    a_l = 13'(2 * (n - 1)) + (sel ? boot_l : 13'h0);
    a_s = 13'(n - 1) + (sel ? boot_s : 13'h0);
    check_val(lf_l, mk(1'b0, n, a_l));
    check_val(lf_s, mk(1'b0, n, a_s));
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    fuse = 1'b1;
    boot_l = 13'h1c00;
    boot_s = 13'h0c00;
    ctrl_wr = 1'b0;
    ctrl_wdata = 2'h0;
    gie = 1'b0;
    req = '0;
    en = '0;
    errors = 0;
    compares = 0;
    do_reset(1'b1);
    check_val(lf_l, mk(1'b1, 1, 13'h0000));
    check_val(lf_s, mk(1'b1, 1, 13'h0000));
    for (int n = 2; n <= 26; n++)
      take(25'h1 << (n - 2), 25'h1 << (n - 2), n, 1'b0);
    // Select write without unlock, then after the window ran out
    ctrl_write(2'h2);
    @(negedge clk);
    check_val(ctl_l, 2'h0);
    ctrl_write(2'h1);
    @(negedge clk);
    check_val(ctl_l, 2'h1);
    repeat (6) @(negedge clk);
    check_val(ctl_l, 2'h0);
    ctrl_write(2'h2);
    @(negedge clk);
    check_val(ctl_l, 2'h0);
    set_select();
    for (int n = 2; n <= 26; n++)
      take(25'h1 << (n - 2), 25'h1 << (n - 2), n, 1'b1);
    take(25'h1ffffff, 25'h0000088, 5, 1'b1);
    // Requests with every enable low must never be dispatched
    @(negedge clk);
    req = 25'h1ffffff;
    en = '0;
    gie = 1'b1;
    c = cnt_l;
    repeat (10) @(negedge clk);
    check_val(pend_l, 1'b0);
    check_val(pend_s, 1'b0);
    check_val(19'(cnt_l - c), 19'h0);
    req = '0;
    gie = 1'b0;
    do_reset(1'b0);
    check_val(lf_l, mk(1'b1, 1, 13'h1c00));
    check_val(lf_s, mk(1'b1, 1, 13'h0c00));
    check_val(ctl_l, 2'h0);
    take(25'h1, 25'h1, 2, 1'b0);
    set_select();
    take(25'h1000000, 25'h1000000, 26, 1'b1);
    print_verdict();
  end

  // Whole run is under a thousand cycles; this bound is generous
  initial begin
    repeat (6000) @(posedge clk);
    errors++;
    print_verdict();
  end
endmodule

//--- tb/rivp_core_model.sv
// Behavioural model of the processor core that acknowledges pending
// interrupts and records every fetch request handed to it.
// Assumes it shares clk_i with the vector block; ack is a one-cycle pulse.
`timescale 1ns/100ps
module rivp_core_model
  import rivp_pkg::*;
#(
  parameter int DELAY = 0
) (
  input wire logic clk_i,
  input wire logic irq_pending_i,
  input wire logic fetch_valid_i,
  input wire rivp_fetch_t fetch_i,
  output logic irq_ack_o,
  output rivp_fetch_t last_fetch_o,
  output int fetch_cnt_o
);
  int wait_cnt;

  // ****************************************************************
  // Acknowledge side
  // ****************************************************************
  initial begin
    irq_ack_o = 1'b0;
    last_fetch_o = '0;
    fetch_cnt_o = 0;
    wait_cnt = 0;
  end

  // Waits DELAY pending cycles, so a slow core is modelled as well
  always @(posedge clk_i) begin
    if (irq_pending_i && !irq_ack_o && wait_cnt >= DELAY) begin
      irq_ack_o <= 1'b1;
      wait_cnt <= 0;
    end else begin
      irq_ack_o <= 1'b0; // Pulse only, never held across dispatch
      wait_cnt <= irq_pending_i ? wait_cnt + 1 : 0;
    end
  end

  // Fetch capture, valid stands a single cycle
  always @(posedge clk_i) begin
    if (fetch_valid_i) begin
      last_fetch_o <= fetch_i;
      fetch_cnt_o <= fetch_cnt_o + 1;
    end
  end
endmodule
